// ---- src/mrs_pkg.sv ----
// constants and carrier types for the reset sequencer
package mrs_pkg;
  localparam int unsigned SYS_CLK_HZ       = 50_000_000;
  localparam int unsigned PHASES_PER_MC    = 12;
  localparam logic [3:0]  PH_S5P1          = 4'h8;
  localparam logic [3:0]  PH_S5P2          = 4'h9;
  localparam logic [3:0]  PH_LAST          = 4'hB;
  localparam logic [3:0]  PH_ALE_HI_A      = 4'h2;
  localparam logic [3:0]  PH_ALE_HI_B      = 4'h8;
  localparam int unsigned OSC_STAB_RC_CYC  = 768;
  localparam logic [1:0]  RC_FASTER_CNT    = 2'h2;
  localparam logic [15:0] RESET_VECTOR     = 16'h0000;
  localparam logic [7:0]  PORT_LATCH_RST   = 8'hFF;
  localparam logic [7:0]  PORT2_EA_LOW     = 8'h00;
  localparam logic [7:0]  PORT2_EA_HIGH    = 8'hFF;
  localparam int unsigned SYNC_STAGES      = 2;
  localparam logic        SEL_RC           = 1'b0;
  localparam logic        SEL_OSC          = 1'b1;
  localparam logic [3:0]  SWITCH_GAP       = 4'h6;
  localparam logic [3:0]  GAP_SAT          = 4'hF;

  typedef enum logic [1:0] {
    MRS_HOLD  = 2'b00,
    MRS_START = 2'b01,
    MRS_RUN   = 2'b11
  } mrs_state_t;

  typedef struct packed {
    logic [7:0] p5;
    logic [7:0] p4;
    logic [7:0] p3;
    logic [7:0] p2;
    logic [7:0] p1;
    logic [7:0] p0;
  } mrs_port_t;
endpackage : mrs_pkg

// ---- src/mrs_sync.sv ----
// multi-flop synchroniser for pin levels
module mrs_sync #(
  parameter int unsigned WIDTH  = 1,
  parameter int unsigned STAGES = 2
) (
  input  wire logic             sys_clk, // system clock
  input  wire logic             reset,   // async reset, high
  input  wire logic [WIDTH-1:0] rst_val, // unused at reset, see note
  input  wire logic [WIDTH-1:0] d_in,    // asynchronous level
  output logic      [WIDTH-1:0] q_out    // synchronised level
);
  logic [WIDTH-1:0] stage_ff [STAGES];

  initial
  begin
    if (STAGES < 2)
      $error("mrs_sync needs at least two stages");
  end

  // reset value must be constant; rst_val only kept for port symmetry
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < STAGES; i++)
        stage_ff[i] <= '0;
    end
    else
    begin
      stage_ff[0] <= d_in;
      for (int i = 1; i < STAGES; i++)
        stage_ff[i] <= stage_ff[i-1];
    end
  end

  assign q_out = stage_ff[STAGES-1];
endmodule : mrs_sync

// ---- src/mrs_reset_seq.sv ----
// reset sequencer with oscillator watchdog and clock selection
module mrs_reset_seq #(
  parameter int unsigned STAB_CYC = mrs_pkg::OSC_STAB_RC_CYC
) (
  input  wire logic             sys_clk,                 // 50 MHz clock
  input  wire logic             reset,                   // async, high
  input  wire logic             ext_reset_n,             // reset pin, low
  input  wire logic             osc_clk_pin,             // on-chip osc
  input  wire logic             rc_clk_pin,              // RC aux osc
  input  wire logic             external_access_select,  // pin level
  input  wire logic             wdt_reset_req,           // watchdog timer
  input  wire logic [7:0]       port6_pins,              // input-only port
  input  wire logic             cpu_ram_we,              // core RAM write
  output logic                  chip_tick,               // chip phase enable
  output logic                  clk_sel_osc,             // 1: on-chip osc
  output logic                  int_reset,               // internal reset
  output logic                  osc_watchdog_fail_flag,  // failure status
  output logic                  power_down_exit,         // one-cycle pulse
  output mrs_pkg::mrs_port_t    port_latch,              // port latches
  output logic [7:0]            input_only_port_reg,     // live port 6
  output logic                  ram_we,                  // gated RAM write
  output logic                  fetch_start,             // first fetch pulse
  output logic [15:0]           fetch_addr,              // fetch address
  output logic                  addr_out_en,             // bus address on
  output logic                  ale_out,                 // ALE drive value
  output logic                  ale_oe_n,                // low: driving
  output logic                  program_fetch_strobe,    // drive value, low
  output logic                  program_fetch_strobe_oe_n // low: driving
);
  localparam logic [9:0] STAB_LAST = 10'(STAB_CYC - 1);

  initial
  begin
    if (STAB_CYC < 1 || STAB_CYC > 1024)
      $error("STAB_CYC must be 1..1024");
  end

  logic             rst_sync_n;
  logic             osc_sync;
  logic             rc_sync;
  logic             ea_sync;
  logic [7:0]       p6_sync;
  logic             wdt_sync;

  // every pin level crosses two flops before use
  mrs_sync #(.WIDTH(13), .STAGES(mrs_pkg::SYNC_STAGES)) u_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .rst_val (13'h0000),
    .d_in    ({ext_reset_n, osc_clk_pin, rc_clk_pin,
               external_access_select, port6_pins, wdt_reset_req}),
    .q_out   ({rst_sync_n, osc_sync, rc_sync,
               ea_sync, p6_sync, wdt_sync})
  );

  logic             osc_d_ff;
  logic             rc_d_ff;
  logic [1:0]       rc_cnt_ff;
  logic [9:0]       stab_cnt_ff;
  logic             owd_rst_ff;
  logic             sel_ff;
  logic [3:0]       phase_ff;
  logic             ext_act_ff;
  logic             flag_ff;
  logic             pdx_ff;
  logic             ale_ff;
  logic             program_fetch_strobe_ff;
  logic             fs_ff;
  logic             aoe_ff;
  logic             ireset_ff;
  logic [3:0]       gap_ff;
  mrs_pkg::mrs_port_t   port_ff;
  mrs_pkg::mrs_state_t  state_ff;
  mrs_pkg::mrs_state_t  nxt_state;

  wire osc_tick   = osc_sync & ~osc_d_ff;
  wire rc_tick    = rc_sync & ~rc_d_ff;
  wire fail_now   = (rc_cnt_ff == mrs_pkg::RC_FASTER_CNT);
  wire want_osc   = ~owd_rst_ff;
  // switch only with no edge from either source and the last tick
  // far enough back that the first new tick cannot come too soon
  wire gap_ok     = (gap_ff >= mrs_pkg::SWITCH_GAP);
  wire quiet      = ~osc_tick & ~rc_tick & gap_ok;
  wire nxt_sel    = quiet ? want_osc : sel_ff;
  wire tick       = sel_ff ? osc_tick : rc_tick;
  wire at_s5p2    = tick & (phase_ff == mrs_pkg::PH_S5P2);
  wire at_s5p1    = tick & (phase_ff == mrs_pkg::PH_S5P1);
  wire samp_low   = at_s5p2 & ~rst_sync_n;
  wire samp_high  = at_s5p2 & rst_sync_n;
  wire stab_done  = rc_tick & ~fail_now & (stab_cnt_ff == STAB_LAST);
  wire nxt_ireset = ext_act_ff | owd_rst_ff | wdt_sync;
  // a release seen at this S5P2 lets the start phase begin at once
  wire ext_next   = samp_low | (ext_act_ff & ~samp_high);
  wire hold_req   = ext_next | owd_rst_ff | wdt_sync;
  wire [7:0] p2_rst = ea_sync ? mrs_pkg::PORT2_EA_HIGH
                              : mrs_pkg::PORT2_EA_LOW;
  wire ale_hi     = (phase_ff == mrs_pkg::PH_ALE_HI_A) |
                    (phase_ff == mrs_pkg::PH_ALE_HI_B);
  wire program_fetch_strobe_lo    = (phase_ff > mrs_pkg::PH_ALE_HI_A &&
                     phase_ff < 4'h6) | (phase_ff > mrs_pkg::PH_ALE_HI_B);
  wire running    = (state_ff == mrs_pkg::MRS_RUN);

  // the osc pin must toggle slower than a quarter of sys_clk
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      osc_d_ff <= 1'b0;
      rc_d_ff  <= 1'b0;
    end
    else
    begin
      osc_d_ff <= osc_sync;
      rc_d_ff  <= rc_sync;
    end
  end

  // two RC edges without an osc edge means RC runs faster
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      rc_cnt_ff <= mrs_pkg::RC_FASTER_CNT;
    else if (osc_tick)
      rc_cnt_ff <= 2'h0;
    else if (rc_tick && !fail_now)
      rc_cnt_ff <= rc_cnt_ff + 2'h1;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      stab_cnt_ff <= 10'h000;
    else if (fail_now || stab_done)
      stab_cnt_ff <= 10'h000;
    else if (rc_tick && owd_rst_ff)
      stab_cnt_ff <= stab_cnt_ff + 10'h001;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      owd_rst_ff <= 1'b1;
    else if (fail_now)
      owd_rst_ff <= 1'b1;
    else if (stab_done)
      owd_rst_ff <= 1'b0;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      sel_ff <= mrs_pkg::SEL_RC;
    else
      sel_ff <= nxt_sel;
  end

  // cycles since the last chip tick, saturating
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      gap_ff <= mrs_pkg::GAP_SAT;
    else if (tick)
      gap_ff <= 4'h0;
    else if (gap_ff != mrs_pkg::GAP_SAT)
      gap_ff <= gap_ff + 4'h1;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      phase_ff <= 4'h0;
    else if (tick)
      phase_ff <= (phase_ff == mrs_pkg::PH_LAST) ? 4'h0
                                                 : phase_ff + 4'h1;
  end

  // internal reset starts two sys_clk cycles after the low sample, still in the same machine cycle
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      ext_act_ff <= 1'b0;
    else if (samp_low)
      ext_act_ff <= 1'b1;
    else if (samp_high)
      ext_act_ff <= 1'b0;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      ireset_ff <= 1'b1;
    else
      ireset_ff <= nxt_ireset;
  end

  // set wins over the clear by an external reset sample
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      flag_ff <= 1'b1;
    else if (fail_now)
      flag_ff <= 1'b1;
    else if (samp_low)
      flag_ff <= 1'b0;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      pdx_ff <= 1'b0;
    else
      pdx_ff <= samp_low & ~ext_act_ff;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      port_ff <= {6{mrs_pkg::PORT_LATCH_RST}};
    else if (ireset_ff && tick)
    begin
      port_ff    <= {6{mrs_pkg::PORT_LATCH_RST}};
      port_ff.p2 <= p2_rst;
    end
  end

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      mrs_pkg::MRS_HOLD:
        if (!hold_req && at_s5p2)
          nxt_state = mrs_pkg::MRS_START;
      mrs_pkg::MRS_START:
        if (nxt_ireset)
          nxt_state = mrs_pkg::MRS_HOLD;
        else if (at_s5p1)
          nxt_state = mrs_pkg::MRS_RUN;
      mrs_pkg::MRS_RUN:
        if (nxt_ireset)
          nxt_state = mrs_pkg::MRS_HOLD;
      default:
        nxt_state = mrs_pkg::MRS_HOLD;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      state_ff <= mrs_pkg::MRS_HOLD;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      fs_ff   <= 1'b0;
      aoe_ff  <= 1'b0;
      ale_ff  <= 1'b0;
      program_fetch_strobe_ff <= 1'b1;
    end
    else
    begin
      fs_ff  <= (state_ff == mrs_pkg::MRS_START) & at_s5p1;
      aoe_ff <= (nxt_state == mrs_pkg::MRS_RUN);
      if (nxt_state != mrs_pkg::MRS_RUN)
      begin
        ale_ff  <= 1'b0;
        program_fetch_strobe_ff <= 1'b1;
      end
      else if (tick || at_s5p1)
      begin
        ale_ff  <= at_s5p1 | (ale_hi & ~tick);
        program_fetch_strobe_ff <= ~(program_fetch_strobe_lo & ~at_s5p1);
      end
    end
  end

  assign chip_tick                 = tick;
  assign clk_sel_osc               = sel_ff;
  assign int_reset                 = ireset_ff;
  assign osc_watchdog_fail_flag    = flag_ff;
  assign power_down_exit           = pdx_ff;
  assign port_latch                = port_ff;
  assign input_only_port_reg       = p6_sync;
  assign ram_we                    = cpu_ram_we & ~ireset_ff;
  assign fetch_start               = fs_ff;
  assign fetch_addr                = mrs_pkg::RESET_VECTOR;
  assign addr_out_en               = aoe_ff;
  assign ale_out                   = ale_ff;
  assign program_fetch_strobe      = program_fetch_strobe_ff;
  assign ale_oe_n                  = ~running;
  assign program_fetch_strobe_oe_n = ~running;

  property p_fail_forces_reset;
    @(posedge sys_clk) disable iff (reset)
    fail_now |=> owd_rst_ff ##1 ireset_ff;
  endproperty
  a_fail_forces_reset: assert property (p_fail_forces_reset)
    else $error("osc failure did not force reset");

  property p_stab_release;
    @(posedge sys_clk) disable iff (reset)
    stab_done |=> !owd_rst_ff;
  endproperty
  a_stab_release: assert property (p_stab_release)
    else $error("watchdog reset not released after stabilisation");

  property p_no_early_release;
    @(posedge sys_clk) disable iff (reset)
    $fell(owd_rst_ff) |-> $past(stab_cnt_ff) == STAB_LAST;
  endproperty
  a_no_early_release: assert property (p_no_early_release)
    else $error("watchdog reset released before count ended");

  property p_switch_quiet;
    @(posedge sys_clk) disable iff (reset)
    $changed(sel_ff) |-> $past(quiet);
  endproperty
  a_switch_quiet: assert property (p_switch_quiet)
    else $error("clock switched on a source edge");

  property p_ext_hold;
    @(posedge sys_clk) disable iff (reset)
    ext_act_ff |=> ireset_ff;
  endproperty
  a_ext_hold: assert property (p_ext_hold)
    else $error("left reset while external reset active");

  property p_pins_input;
    @(posedge sys_clk) disable iff (reset)
    ireset_ff |-> ale_oe_n && program_fetch_strobe_oe_n;
  endproperty
  a_pins_input: assert property (p_pins_input)
    else $error("strobe pins driven during reset");

  property p_ram_safe;
    @(posedge sys_clk) disable iff (reset)
    ireset_ff |-> !ram_we;
  endproperty
  a_ram_safe: assert property (p_ram_safe)
    else $error("RAM written during reset");

  property p_flag_clear;
    @(posedge sys_clk) disable iff (reset)
    samp_low && !fail_now |=> !flag_ff;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("fail flag not cleared by external reset");

  property p_first_ale_fall;
    @(posedge sys_clk) disable iff (reset)
    fs_ff |-> ale_ff ##[1:1000] ($fell(ale_ff) && $past(at_s5p2));
  endproperty
  a_first_ale_fall: assert property (p_first_ale_fall)
    else $error("first ALE fall missing after start");

  property p_port_load;
    @(posedge sys_clk) disable iff (reset)
    ireset_ff && tick |=> port_ff.p0 == mrs_pkg::PORT_LATCH_RST &&
                         port_ff.p2 == $past(p2_rst);
  endproperty
  a_port_load: assert property (p_port_load)
    else $error("port latches not loaded in reset");

  c_fail_seen:   cover property (@(posedge sys_clk) fail_now);
  c_osc_switch:  cover property (@(posedge sys_clk) $rose(sel_ff));
  c_first_fetch: cover property (@(posedge sys_clk) fs_ff);
  c_ext_reset:   cover property (@(posedge sys_clk) samp_low ##1 pdx_ff);
endmodule : mrs_reset_seq

// ---- test/mrs_reset_src.sv ----
// far-side model: reset pin source plus the crystal and RC oscillators
module mrs_reset_src #(
  parameter int unsigned OSC_HALF = 5,
  parameter int unsigned RC_HALF  = 12,
  parameter int unsigned MIN_OSC  = 24
) (
  input  wire logic sys_clk,     // bench clock
  input  wire logic osc_run,     // crystal has started
  input  wire logic rst_req,     // bench asks for the pin low
  output logic      ext_reset_n, // reset pin level
  output logic      osc_clk_pin, // crystal oscillator level
  output logic      rc_clk_pin   // RC oscillator level
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned osc_div;
  int unsigned rc_div;
  int unsigned held;

  initial
  begin
    osc_clk_pin = 1'b0;
    rc_clk_pin  = 1'b0;
    ext_reset_n = 1'b0;
    osc_div     = 0;
    rc_div      = 0;
    held        = 0;
  end

  // no connection to the strobe pins: never driven from outside
  always @(posedge sys_clk)
  begin
    rc_div <= (rc_div == RC_HALF - 1) ? 0 : rc_div + 1;
    if (rc_div == RC_HALF - 1)
      rc_clk_pin <= ~rc_clk_pin;
    // a stopped crystal freezes at its last level
    if (osc_run)
    begin
      osc_div <= (osc_div == OSC_HALF - 1) ? 0 : osc_div + 1;
      if (osc_div == OSC_HALF - 1)
        osc_clk_pin <= ~osc_clk_pin;
    end
    if (ext_reset_n)
      held <= 0;
    else if (osc_run && osc_div == OSC_HALF - 1 && !osc_clk_pin)
      held <= held + 1;
    if (rst_req)
      ext_reset_n <= 1'b0;
    else if (held >= MIN_OSC)
      ext_reset_n <= 1'b1;
  end
endmodule : mrs_reset_src

// ---- test/mrs_reset_seq_bench.sv ----
// self-checking bench for the reset sequencer
module mrs_reset_seq_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STAB   = 8;
  localparam int RC_PER = 24;
  localparam int MC_CYC = 120; // one osc machine cycle in sys_clk cycles
  logic sys_clk, reset, osc_run, rst_req, ea, wdt, ram_req;
  logic [7:0] p6, p6reg;
  logic ext_reset_n, osc_clk_pin, rc_clk_pin;
  logic chip_tick, clk_sel_osc, int_reset, flag, pde, ram_we;
  logic fetch_start, addr_out_en, ale_out, ale_oe_n, pfs, pfs_oe_n;
  logic [15:0] fetch_addr;
  mrs_pkg::mrs_port_t port_latch;
  int bad_count, samples_checked, n, gap;
  integer seed;
  wire [6:0] ev = {ext_reset_n, ale_out, pde, fetch_start, flag,
                   clk_sel_osc, int_reset};

  mrs_reset_src i_mrs_reset_src (.sys_clk(sys_clk), .osc_run(osc_run),
    .rst_req(rst_req), .ext_reset_n(ext_reset_n),
    .osc_clk_pin(osc_clk_pin), .rc_clk_pin(rc_clk_pin));

  mrs_reset_seq #(.STAB_CYC(STAB)) i_mrs_reset_seq (.sys_clk(sys_clk),
    .reset(reset), .ext_reset_n(ext_reset_n), .osc_clk_pin(osc_clk_pin),
    .rc_clk_pin(rc_clk_pin), .external_access_select(ea),
    .wdt_reset_req(wdt), .port6_pins(p6), .cpu_ram_we(ram_req),
    .chip_tick(chip_tick), .clk_sel_osc(clk_sel_osc),
    .int_reset(int_reset), .osc_watchdog_fail_flag(flag),
    .power_down_exit(pde), .port_latch(port_latch),
    .input_only_port_reg(p6reg), .ram_we(ram_we),
    .fetch_start(fetch_start), .fetch_addr(fetch_addr),
    .addr_out_en(addr_out_en), .ale_out(ale_out), .ale_oe_n(ale_oe_n),
    .program_fetch_strobe(pfs), .program_fetch_strobe_oe_n(pfs_oe_n));

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [63:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic done(input string what);
    $display("test %s finished", what);
  endtask : done

  function automatic mrs_pkg::mrs_port_t exp_ports(input logic e);
    exp_ports = {6{mrs_pkg::PORT_LATCH_RST}};
    exp_ports.p2 = e ? mrs_pkg::PORT2_EA_HIGH : mrs_pkg::PORT2_EA_LOW;
  endfunction : exp_ports

  // bounded wait on one event bit, sampled mid-cycle
  task automatic wait_bit(input string what, input int idx, input logic val,
                          input int lim, output int cnt);
    cnt = 0;
    while (ev[idx] !== val && cnt < lim)
    begin
      @(negedge sys_clk);
      cnt++;
    end
    check(what, ev[idx], val);
  endtask : wait_bit

  task automatic io_checks(input logic in_rst);
    logic [7:0] v;
    logic       w;
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($random(seed));
      w = 1'($random(seed));
      @(posedge sys_clk);
      p6 <= v;
      ram_req <= w;
      repeat (3) @(negedge sys_clk);
      check("port6", p6reg, v);
      check("ram_we", ram_we, w & ~in_rst);
    end
  endtask : io_checks

  // ext: the pin itself is being released, so the full delay applies
  task automatic run_release(input logic ext);
    int m;
    @(posedge sys_clk);
    rst_req <= 1'b0;
    wait_bit("pin_high", 6, 1'b1, 400, m);
    wait_bit("fetch", 3, 1'b1, 600, m);
    if (ext)
      check("fetch_delay", m >= 100 && m <= 2 * MC_CYC, 1'b1);
    check("fetch_addr", fetch_addr, mrs_pkg::RESET_VECTOR);
    check("run_rst", int_reset, 1'b0);
    wait_bit("ale_fall", 5, 1'b0, 12, m);
    check("addr_en", addr_out_en, 1'b1);
    check("pfs", pfs, 1'b0);
    check("ale_oe_n", ale_oe_n, 1'b0);
  endtask : run_release

  always @(negedge sys_clk)
  begin
    if (reset)
      gap = 100;
    else if (chip_tick)
    begin
      if (gap < 5)
        check("tick_gap", gap, 5);
      gap = 0;
    end
    else
      gap++;
  end

  initial
  begin
    #400000;
    bad_count++;
    stop_test();
  end

  initial
  begin
    seed = 32'hA3788F94;
    {reset, rst_req} = 2'h3;
    {osc_run, ea, wdt, ram_req} = 4'h0;
    p6 = 8'h00;
    bad_count = 0;
    samples_checked = 0;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (300) @(negedge sys_clk);
    check("int_reset", int_reset, 1'b1);
    check("flag_set", flag, 1'b1);
    check("on_rc", clk_sel_osc, mrs_pkg::SEL_RC);
    check("ports", port_latch, exp_ports(1'b0));
    check("ale_oe_n", ale_oe_n, 1'b1);
    check("pfs_oe_n", pfs_oe_n, 1'b1);
    io_checks(1'b1);
    done("power-up on RC");
    @(posedge sys_clk);
    osc_run <= 1'b1;
    wait_bit("clk_sel", 1, 1'b1, (STAB + 3) * RC_PER, n);
    check("stab_min", n >= (STAB - 1) * RC_PER, 1'b1);
    check("held", int_reset, 1'b1);
    wait_bit("flag_clr", 2, 1'b0, 300, n);
    run_release(1'b1);
    io_checks(1'b0);
    done("start");
    for (int r = 0; r < 3; r++)
    begin
      @(posedge sys_clk);
      ea <= (r == 0) ? 1'b1 : 1'($random(seed));
      rst_req <= 1'b1;
      wait_bit("pd_exit", 4, 1'b1, 260, n);
      wait_bit("int_rst", 0, 1'b1, 4, n);
      repeat (250) @(negedge sys_clk);
      check("ports", port_latch, exp_ports(ea));
      check("pfs_oe_n", pfs_oe_n, 1'b1);
      io_checks(1'b1);
      repeat ($unsigned($random(seed)) % 200) @(posedge sys_clk);
      run_release(1'b1);
    end
    done("external reset in run");
    @(posedge sys_clk);
    wdt <= 1'b1;
    wait_bit("wdt_rst", 0, 1'b1, 8, n);
    repeat (20) @(posedge sys_clk);
    wdt <= 1'b0;
    run_release(1'b0);
    done("watchdog timer");
    @(posedge sys_clk);
    osc_run <= 1'b0;
    wait_bit("fail", 2, 1'b1, 4 * RC_PER, n);
    repeat (4) @(negedge sys_clk);
    check("on_rc", clk_sel_osc, mrs_pkg::SEL_RC);
    check("owd_rst", int_reset, 1'b1);
    @(posedge sys_clk);
    osc_run <= 1'b1;
    wait_bit("clk_sel", 1, 1'b1, (STAB + 3) * RC_PER, n);
    run_release(1'b0);
    check("flag_kept", flag, 1'b1);
    done("oscillator failure");
    stop_test();
  end
endmodule : mrs_reset_seq_bench
